//--- bench/iofs_io_model.sv
// far-side model: fault sources and analog input channels
`timescale 1ns/1ps
module iofs_io_model #(
   parameter int AI_CH = 4
) (
   input wire logic clk,
   output logic bus_off,
   output logic guard_fail,
   output logic [AI_CH*16-1:0] ai_raw,
   output logic [AI_CH-1:0] ai_load
);
   initial begin
      bus_off = 1'b0;
      guard_fail = 1'b0;
      ai_raw = '0;
      ai_load = '0;
   end
   // one fault source high for 8 cycles, src 1 is guarding
   task automatic fault(input logic src);
      @(posedge clk);
      bus_off <= !src;
      guard_fail <= src;
      repeat (8) @(posedge clk);
      bus_off <= 1'b0;
      guard_fail <= 1'b0;
      #1;
   endtask
   // one word with its strobe, then the line changes
   task automatic sample(input int ch, input logic [15:0] v);
      @(posedge clk);
      ai_raw[ch*16+:16] <= v;
      ai_load[ch] <= 1'b1;
      @(posedge clk);
      ai_load[ch] <= 1'b0;
      ai_raw[ch*16+:16] <= ~v;
   endtask
endmodule // iofs_io_model

//--- bench/iofs_top_sva.sv
// port checker for the fault substitution block
`timescale 1ns/1ps
module iofs_top_sva #(
   parameter int DO_BYTES = 2,
   parameter int AO_CH = 2
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [23:0] addr,
   input wire logic [15:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [15:0] rd_data,
   input wire logic bus_off,
   input wire logic guard_fail,
   input wire logic [DO_BYTES*8-1:0] do_out,
   input wire logic [AO_CH*16-1:0] ao_out,
   input wire logic fault_active
);
   logic any_f;
   assign any_f = bus_off | guard_fail;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ************************************************************
   // fault supervision and output image
   // ************************************************************
   sequence calm;
      (!any_f)[*5];
   endsequence
   sequence armed_rise;
      calm ##1 any_f;
   endsequence
   fault_start_a: assert property (armed_rise |-> ##3 fault_active)
      else $error("no fault state");
   fault_cause_a: assert property ($rose(fault_active) |-> $past(any_f, 3))
      else $error("fault without cause");
   fault_hold_a: assert property (any_f[*3] ##0 fault_active |=> fault_active)
      else $error("fault state dropped");
   fault_drop_a: assert property (calm |-> !fault_active)
      else $error("fault state stuck");
   outs_quiet_a: assert property (!wr_en |=> ($stable(do_out) && $stable(ao_out)) || $rose(fault_active))
      else $error("output moved");
   dout_wr_a: assert property (wr_en && addr == 24'h620001 |=>
      do_out[7:0] == $past(wr_data[7:0]) || $rose(fault_active))
      else $error("output byte write");
   aout_wr_a: assert property (wr_en && addr == 24'h641101 |=>
      ao_out[15:0] == $past(wr_data) || $rose(fault_active))
      else $error("analog write");
   dout_rd_a: assert property (rd_en && addr == 24'h620002 |=> rd_data[7:0] == $past(do_out[15:8]))
      else $error("output byte read");
endmodule // iofs_top_sva

//--- bench/test_iofs_top.sv
// self-checking bench for the fault substitution block
`timescale 1ns/1ps
module test_iofs_top import iofs_pkg::*; ;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [23:0] addr = '0;
   iofs_word_t wr_data = '0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   iofs_word_t rd_data;
   logic bus_off, guard_fail, fault_active;
   logic [63:0] ai_raw;
   logic [3:0] ai_load;
   logic [15:0] do_out;
   logic [31:0] ao_out;
   int num_errors = 0;
   int total_checks = 0;
   logic [23:0] rst_a [6] = '{24'h620601, 24'h620701, 24'h644301, 24'h644401, 24'h644302, 24'h620003};
   iofs_word_t raw_v [5] = '{16'h7000, 16'h8000, 16'h0010, 16'h0100, 16'hff00};
   iofs_word_t exp_v [5] = '{16'h0100, 16'hff00, 16'h0010, 16'h0100, 16'hff00};
   initial begin
      forever #5 clk = ~clk;
   end
   iofs_top uut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
      .rd_en(rd_en), .rd_data(rd_data), .bus_off(bus_off), .guard_fail(guard_fail), .ai_raw(ai_raw),
      .ai_load(ai_load), .do_out(do_out), .ao_out(ao_out), .fault_active(fault_active));
   iofs_io_model io (.clk(clk), .bus_off(bus_off), .guard_fail(guard_fail), .ai_raw(ai_raw),
      .ai_load(ai_load));
   // ************************************************************
   // bus tasks and comparisons
   // ************************************************************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input iofs_word_t got, input iofs_word_t exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [23:0] a, input iofs_word_t d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [23:0] a, input iofs_word_t exp);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(rd_data, exp);
   endtask
   task automatic wait_fa(input logic lvl);
      int n = 0;
      while (fault_active !== lvl && n < 20) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (fault_active !== lvl) begin
         num_errors++;
         $display("[FAIL] %0t fault state wait", $time);
         complete_run();
      end
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (rst_a[i]) begin
         rd_chk(rst_a[i], 16'h0000);
      end
      $display("reset test done");
      wr(24'h620001, 16'h00a5);
      wr(24'h620002, 16'h003c);
      wr(24'h641101, 16'h8001);
      wr(24'h641102, 16'h1234);
      wr(24'h620003, 16'h00ff);
      wr(24'h640101, 16'h5555);
      chk(do_out, 16'h3ca5);
      chk(ao_out[15:0], 16'h8001);
      chk(ao_out[31:16], 16'h1234);
      rd_chk(24'h620002, 16'h003c);
      rd_chk(24'h641101, 16'h8001);
      rd_chk(24'h640101, 16'h0000);
      $display("readback test done");
      wr(24'h620001, 16'h000f);
      wr(24'h620601, 16'h0031);
      wr(24'h620701, 16'h00f8);
      wr(24'h620002, 16'h00ff);
      wr(24'h644301, 16'h0001);
      wr(24'h644401, 16'h7000);
      wr(24'h644302, 16'h0002);
      wr(24'h644402, 16'h5555);
      io.fault(1'b0);
      wait_fa(1'b1);
      chk(do_out, 16'hff3e);
      chk(ao_out[15:0], 16'h7000);
      chk(ao_out[31:16], 16'h1234);
      rd_chk(24'h620001, 16'h003e);
      wait_fa(1'b0);
      wr(24'h620001, 16'h0000);
      wr(24'h641101, 16'h0000);
      io.fault(1'b1);
      wait_fa(1'b1);
      chk(do_out, 16'hff30);
      chk(ao_out[15:0], 16'h7000);
      wait_fa(1'b0);
      rd_chk(24'h210201, 16'h0208);
      wr(24'h210201, 16'h0008);
      rd_chk(24'h210201, 16'h0200);
      $display("fault test done");
      wr(24'h210001, 16'hff00);
      wr(24'h210101, 16'h0100);
      rd_chk(24'h210101, 16'h0100);
      rd_chk(24'h210104, 16'h7fff);
      for (int i = 0; i < 5; i++) begin
         io.sample(0, raw_v[i]);
         rd_chk(24'h640101, exp_v[i]);
      end
      io.sample(3, 16'h8000);
      rd_chk(24'h640104, 16'h8000);
      $display("clamp test done");
      complete_run();
   end
endmodule // test_iofs_top

bind iofs_top iofs_top_sva #(.DO_BYTES(DO_BYTES), .AO_CH(AO_CH)) sva_i (.clk(clk), .sys_rst(sys_rst),
   .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .bus_off(bus_off),
   .guard_fail(guard_fail), .do_out(do_out), .ao_out(ao_out), .fault_active(fault_active));

//--- hw/iofs_cfg.svh
// offsets, field positions, reset values and widths of the fault substitution block
`ifndef IOFS_CFG_SVH
`define IOFS_CFG_SVH

// ************************************************************
// object indices, address bits [23:8]
// ************************************************************
`define IOFS_IDX_DOUT 16'h6200
`define IOFS_IDX_DFEN 16'h6206
`define IOFS_IDX_DFVAL 16'h6207
`define IOFS_IDX_AIN 16'h6401
`define IOFS_IDX_AOUT 16'h6411
`define IOFS_IDX_AFEN 16'h6443
`define IOFS_IDX_AFVAL 16'h6444
`define IOFS_IDX_RMIN 16'h2100
`define IOFS_IDX_RMAX 16'h2101
`define IOFS_IDX_STAT 16'h2102

// ************************************************************
// address layout and data width
// ************************************************************
`define IOFS_ADDR_W 24
`define IOFS_DATA_W 16
`define IOFS_IDX_MSB 23
`define IOFS_IDX_LSB 8
`define IOFS_SUB_MSB 7

// ************************************************************
// reset values and the analog fault-enable code
// ************************************************************
`define IOFS_RST_DOUT 8'h00
`define IOFS_RST_DFEN 8'h00
`define IOFS_RST_DFVAL 8'h00
`define IOFS_RST_AOUT 16'h0000
`define IOFS_RST_AFEN 16'h0000
`define IOFS_RST_AFVAL 16'h0000
`define IOFS_RST_RMIN 16'h8000
`define IOFS_RST_RMAX 16'h7fff
`define IOFS_AFEN_ON 16'h0001

// ************************************************************
// status word fields
// ************************************************************
`define IOFS_STAT_BUSOFF 0
`define IOFS_STAT_GUARD 1
`define IOFS_STAT_FAULT 2
`define IOFS_STAT_SEEN 3
`define IOFS_STAT_CNT_LSB 8
`define IOFS_STAT_CNT_MSB 15

`endif

//--- hw/iofs_clamp.sv
// analog input word store with clamping to the channel range
`timescale 1ns/1ps
module iofs_clamp
   import iofs_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [15:0] raw,
   input wire logic [15:0] lo,
   input wire logic [15:0] hi,
   output logic [15:0] word
);

   typedef struct packed {
      iofs_word_t val;
   } iofs_clamp_s;

   iofs_clamp_s s_q;
   iofs_clamp_s s_d;

   always_comb begin
      s_d = s_q;
      if (load) begin
         if ($signed(raw) > $signed(hi)) begin
            s_d.val = hi;
         end else if ($signed(raw) < $signed(lo)) begin
            s_d.val = lo;
         end else begin
            s_d.val = raw;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign word = s_q.val;

endmodule // iofs_clamp

//--- hw/iofs_pkg.sv
// types shared by the fault substitution block
package iofs_pkg;

   // ************************************************************
   // fault supervision states, one-hot
   // ************************************************************
   typedef enum logic [1:0] {
      IOFS_ST_RUN = 2'b01,
      IOFS_ST_FAULT = 2'b10
   } iofs_state_e;

   // ************************************************************
   // register selection
   // ************************************************************
   typedef enum logic [3:0] {
      IOFS_SEL_NONE = 4'h0,
      IOFS_SEL_DOUT = 4'h1,
      IOFS_SEL_DFEN = 4'h2,
      IOFS_SEL_DFVAL = 4'h3,
      IOFS_SEL_AIN = 4'h4,
      IOFS_SEL_AOUT = 4'h5,
      IOFS_SEL_AFEN = 4'h6,
      IOFS_SEL_AFVAL = 4'h7,
      IOFS_SEL_RMIN = 4'h8,
      IOFS_SEL_RMAX = 4'h9,
      IOFS_SEL_STAT = 4'ha
   } iofs_sel_e;

   typedef logic [15:0] iofs_word_t;

endpackage : iofs_pkg

//--- hw/iofs_sync.sv
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module iofs_sync #(
   parameter int W = 2
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } iofs_sync_s;

   iofs_sync_s s_q;
   iofs_sync_s s_d;

   always_comb begin
      s_d.meta = din;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.stable;

endmodule // iofs_sync

//--- hw/iofs_top.sv
// process image with fault substitution for digital and analog channels
`timescale 1ns/1ps
`include "iofs_cfg.svh"

// What this block does
// - bus-off or guarding failure starts fault handling
// - digital substitution only where enable bit set
// - enabled digital channel takes fault-value bit
// - disabled digital channels keep their state
// - output byte holds eight channels, read/write
// - digital fault-enable byte resets to zero
// - analog substitution only when enable equals one
// - enabled analog channel takes fault-value word
// - analog fault enable and value reset zero
// - analog input read as 16-bit signed word
// - input above range replaced by maximum
// - input below range replaced by minimum
// - analog setpoint word writable and readable
module iofs_top
   import iofs_pkg::*;
#(
   parameter int DO_BYTES = 2,
   parameter int AO_CH = 2,
   parameter int AI_CH = 4
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [`IOFS_ADDR_W-1:0] addr,
   input wire logic [`IOFS_DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [`IOFS_DATA_W-1:0] rd_data,
   input wire logic bus_off,
   input wire logic guard_fail,
   input wire logic [AI_CH*16-1:0] ai_raw,
   input wire logic [AI_CH-1:0] ai_load,
   output logic [DO_BYTES*8-1:0] do_out,
   output logic [AO_CH*16-1:0] ao_out,
   output logic fault_active
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [DO_BYTES-1:0][7:0] dout;
      logic [DO_BYTES-1:0][7:0] dfen;
      logic [DO_BYTES-1:0][7:0] dfval;
      logic [AO_CH-1:0][15:0] aout;
      logic [AO_CH-1:0][15:0] afen;
      logic [AO_CH-1:0][15:0] afval;
      logic [AI_CH-1:0][15:0] rmin;
      logic [AI_CH-1:0][15:0] rmax;
      iofs_state_e st;
      logic prev_flt;
      logic seen;
      logic [7:0] cnt;
      logic [15:0] rdata;
   } iofs_top_s;

   iofs_top_s s_q;
   iofs_top_s s_d;

   logic [1:0] flt_sync;
   logic [AI_CH-1:0][15:0] ai_word;
   logic flt;
   logic flt_event;

   // ************************************************************
   // register decode
   // ************************************************************
   function automatic iofs_sel_e decode(input logic [15:0] idx);
      case (idx)
         `IOFS_IDX_DOUT: decode = IOFS_SEL_DOUT;
         `IOFS_IDX_DFEN: decode = IOFS_SEL_DFEN;
         `IOFS_IDX_DFVAL: decode = IOFS_SEL_DFVAL;
         `IOFS_IDX_AIN: decode = IOFS_SEL_AIN;
         `IOFS_IDX_AOUT: decode = IOFS_SEL_AOUT;
         `IOFS_IDX_AFEN: decode = IOFS_SEL_AFEN;
         `IOFS_IDX_AFVAL: decode = IOFS_SEL_AFVAL;
         `IOFS_IDX_RMIN: decode = IOFS_SEL_RMIN;
         `IOFS_IDX_RMAX: decode = IOFS_SEL_RMAX;
         `IOFS_IDX_STAT: decode = IOFS_SEL_STAT;
         default: decode = IOFS_SEL_NONE;
      endcase
   endfunction

   // channel count behind a register, zero for none
   function automatic int unsigned span(input iofs_sel_e sel);
      case (sel)
         IOFS_SEL_DOUT, IOFS_SEL_DFEN, IOFS_SEL_DFVAL: span = DO_BYTES;
         IOFS_SEL_AIN, IOFS_SEL_RMIN, IOFS_SEL_RMAX: span = AI_CH;
         IOFS_SEL_AOUT, IOFS_SEL_AFEN, IOFS_SEL_AFVAL: span = AO_CH;
         IOFS_SEL_STAT: span = 1;
         default: span = 0;
      endcase
   endfunction

   // ************************************************************
   // fault pins and analog inputs
   // ************************************************************
   iofs_sync #(
      .W(2)
   ) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .din({guard_fail, bus_off}),
      .dout(flt_sync)
   );

   assign flt = flt_sync[0] | flt_sync[1];
   assign flt_event = flt & ~s_q.prev_flt;

   genvar gi;
   generate
      for (gi = 0; gi < AI_CH; gi++) begin : g_ai
         iofs_clamp u_clamp (
            .clk(clk),
            .sys_rst(sys_rst),
            .load(ai_load[gi]),
            .raw(ai_raw[gi*16 +: 16]),
            .lo(s_q.rmin[gi]),
            .hi(s_q.rmax[gi]),
            .word(ai_word[gi])
         );
      end
   endgenerate

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      iofs_sel_e sel;
      int unsigned sub;
      int unsigned ch;
      logic hit;
      sel = decode(addr[`IOFS_IDX_MSB:`IOFS_IDX_LSB]);
      sub = 32'(addr[`IOFS_SUB_MSB:0]);
      ch = (sub == 0) ? 0 : sub - 1;
      hit = (sub != 0) && (sub <= span(sel));
      s_d = s_q;
      s_d.prev_flt = flt;
      s_d.rdata = '0;

      // read data in the following cycle, zero when unmapped
      if (rd_en && hit) begin
         case (sel)
            IOFS_SEL_DOUT: s_d.rdata = {8'h00, s_q.dout[ch]};
            IOFS_SEL_DFEN: s_d.rdata = {8'h00, s_q.dfen[ch]};
            IOFS_SEL_DFVAL: s_d.rdata = {8'h00, s_q.dfval[ch]};
            IOFS_SEL_AIN: s_d.rdata = ai_word[ch];
            IOFS_SEL_AOUT: s_d.rdata = s_q.aout[ch];
            IOFS_SEL_AFEN: s_d.rdata = s_q.afen[ch];
            IOFS_SEL_AFVAL: s_d.rdata = s_q.afval[ch];
            IOFS_SEL_RMIN: s_d.rdata = s_q.rmin[ch];
            IOFS_SEL_RMAX: s_d.rdata = s_q.rmax[ch];
            IOFS_SEL_STAT: begin
               s_d.rdata[`IOFS_STAT_BUSOFF] = flt_sync[0];
               s_d.rdata[`IOFS_STAT_GUARD] = flt_sync[1];
               s_d.rdata[`IOFS_STAT_FAULT] = (s_q.st == IOFS_ST_FAULT);
               s_d.rdata[`IOFS_STAT_SEEN] = s_q.seen;
               s_d.rdata[`IOFS_STAT_CNT_MSB:`IOFS_STAT_CNT_LSB] = s_q.cnt;
            end
            default: s_d.rdata = '0;
         endcase
      end

      if (wr_en && hit) begin
         case (sel)
            IOFS_SEL_DOUT: s_d.dout[ch] = wr_data[7:0];
            IOFS_SEL_DFEN: s_d.dfen[ch] = wr_data[7:0];
            IOFS_SEL_DFVAL: s_d.dfval[ch] = wr_data[7:0];
            IOFS_SEL_AOUT: s_d.aout[ch] = wr_data;
            IOFS_SEL_AFEN: s_d.afen[ch] = wr_data;
            IOFS_SEL_AFVAL: s_d.afval[ch] = wr_data;
            IOFS_SEL_RMIN: s_d.rmin[ch] = wr_data;
            IOFS_SEL_RMAX: s_d.rmax[ch] = wr_data;
            IOFS_SEL_STAT: begin
               if (wr_data[`IOFS_STAT_SEEN]) begin
                  s_d.seen = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // supervision sequence
      case (s_q.st)
         IOFS_ST_RUN: begin
            if (flt_event) begin
               s_d.st = IOFS_ST_FAULT;
            end
         end
         IOFS_ST_FAULT: begin
            if (!flt) begin
               s_d.st = IOFS_ST_RUN;
            end
         end
         default: s_d.st = IOFS_ST_RUN;
      endcase

      // substitution on the fault edge, wins over a same-cycle write
      if (flt_event) begin
         s_d.seen = 1'b1;
         s_d.cnt = s_q.cnt + 8'h01;
         for (int b = 0; b < DO_BYTES; b++) begin
            s_d.dout[b] = (s_d.dout[b] & ~s_q.dfen[b]) | (s_q.dfval[b] & s_q.dfen[b]);
         end
         for (int a = 0; a < AO_CH; a++) begin
            if (s_q.afen[a] == `IOFS_AFEN_ON) begin
               s_d.aout[a] = s_q.afval[a];
            end
         end
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int b = 0; b < DO_BYTES; b++) begin
            s_q.dout[b] <= `IOFS_RST_DOUT;
            s_q.dfen[b] <= `IOFS_RST_DFEN;
            s_q.dfval[b] <= `IOFS_RST_DFVAL;
         end
         for (int a = 0; a < AO_CH; a++) begin
            s_q.aout[a] <= `IOFS_RST_AOUT;
            s_q.afen[a] <= `IOFS_RST_AFEN;
            s_q.afval[a] <= `IOFS_RST_AFVAL;
         end
         for (int i = 0; i < AI_CH; i++) begin
            s_q.rmin[i] <= `IOFS_RST_RMIN;
            s_q.rmax[i] <= `IOFS_RST_RMAX;
         end
         s_q.st <= IOFS_ST_RUN;
         s_q.prev_flt <= 1'b0;
         s_q.seen <= 1'b0;
         s_q.cnt <= 8'h00;
         s_q.rdata <= 16'h0000;
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign rd_data = s_q.rdata;
   assign do_out = s_q.dout;
   assign ao_out = s_q.aout;
   // one-hot fault state bit, straight from the register
   assign fault_active = s_q.st[1];

endmodule // iofs_top
